//--- flash_control_pkg.sv
// package: register map, control fields and reset values of the flash controller
package flash_control_pkg;
  // register byte offsets
  localparam logic [11:0] OFF_FLASH_CONTROL = 12'h000;
  localparam logic [11:0] OFF_PROGRAM_TIME = 12'h008;
  localparam logic [11:0] OFF_BRIDGE_WAIT_STATES = 12'h010;
  localparam logic [11:0] OFF_PROGRAM_CLOCK_DIVIDER = 12'h01c;
  localparam logic [11:0] OFF_SELFTEST_START_ADDRESS = 12'h020;
  localparam logic [11:0] OFF_SELFTEST_STOP_ADDRESS = 12'h024;
  localparam logic [11:0] OFF_SIGNATURE_WORD_0 = 12'h02c;
  localparam logic [11:0] OFF_SIGNATURE_WORD_1 = 12'h030;
  localparam logic [11:0] OFF_SIGNATURE_WORD_2 = 12'h034;
  localparam logic [11:0] OFF_SIGNATURE_WORD_3 = 12'h038;
  localparam logic [11:0] OFF_IRQ_ENABLE_CLEAR = 12'hfd8;
  localparam logic [11:0] OFF_IRQ_ENABLE_SET = 12'hfdc;
  localparam logic [11:0] OFF_IRQ_PENDING = 12'hfe0;
  localparam logic [11:0] OFF_IRQ_MASK = 12'hfe4;
  localparam logic [11:0] OFF_IRQ_PENDING_CLEAR = 12'hfe8;
  localparam logic [11:0] OFF_IRQ_PENDING_SET = 12'hfec;
  // flash_control field positions
  localparam int BIT_LOAD_REQUEST = 15;
  localparam int BIT_BUFFER_CLEAR = 14;
  localparam int BIT_BUFFER_BYPASS = 13;
  localparam int BIT_PROGRAM_REQUEST = 12;
  localparam int BIT_SECTOR_LATCH_READ = 11;
  localparam int BIT_LATCH_PRESET = 10;
  localparam int BIT_POWER_DOWN = 9;
  localparam int BIT_WRITE_PROTECT = 7;
  localparam int BIT_PROTECTION_SECTOR_SELECT = 6;
  localparam int BIT_DATA_LATCH_READ = 5;
  localparam int BIT_ASYNC_READ_SELECT = 4;
  localparam int BIT_WRITE_ENABLE_N = 2;
  localparam int BIT_PROGRAM_NOT_ERASE = 1;
  localparam int BIT_CHIP_SELECT = 0;
  // writable bits of flash_control (31..16, 8, 3 reserved; 15 self-clears)
  localparam logic [15:0] FLASH_CONTROL_WMASK = 16'h7ef7;
  // reset values
  localparam logic [15:0] RST_FLASH_CONTROL = 16'h0005;
  localparam logic [15:0] RST_PROGRAM_TIME = 16'h0000;
  localparam logic [15:0] RST_BRIDGE_WAIT_STATES = 16'hc004;
  localparam logic [11:0] RST_PROGRAM_CLOCK_DIVIDER = 12'h000;
  localparam logic [16:0] RST_SELFTEST_ADDRESS = 17'h00000;
  localparam logic [31:0] RST_IRQ = 32'h00000000;
  // writable bits of bridge_wait_states
  localparam logic [15:0] WAIT_STATES_WMASK = 16'hc0ff;
  // read modes steering the array side
  typedef enum logic [1:0] {
    SRC_ARRAY,
    SRC_DATA_LATCH,
    SRC_SECTOR_LATCH,
    SRC_PROTECTION_SECTOR
  } read_source_type;
endpackage : flash_control_pkg

//--- flash_control_regs.sv
// flash controller register file and flash-side control strobes
//
// Function
// - protection sector is never erased
// - data latch read bypasses buffer, full waits
// - data latch read in both timing modes
// - protection sector read bypasses buffer, full waits
// - bit 6 selects protection sector reads
// - bit 5 selects data latch reads
// - bit 15 loads flash, self-clears, reads 0
// - bit 14 sets whole read transfer register
// - bit 13 makes flash reads unbuffered
// - bit 12 requests programming
// - bit 11 selects sector latch reads
// - bit 10 presets data latches to ones
// - bit 9 powers flash down
// - bit 7 one permits program and erase
// - bit 4 selects asynchronous read timing
// - bit 2 active-low program/erase enable
// - bit 1 program when set, else erase
// - reserved control bits read zero
// - interrupt status set and clear registers
// - signature readable as four words from 02c
// - buffers invalidated on init, config, special reads
// - protection sector overlaps array address space
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/1ps
`default_nettype none
module flash_control_regs
  import flash_control_pkg::*;
(
  input wire logic mclk_i, // system clock, 25 MHz
  input wire logic rst_b_i, // synchronous reset, active low
  // avalon-mm slave
  input wire logic [11:0] avs_address_i, // byte address
  input wire logic avs_read_i, // read strobe
  input wire logic avs_write_i, // write strobe
  input wire logic [31:0] avs_writedata_i, // write data
  input wire logic [3:0] avs_byteenable_i, // byte lanes
  output logic [31:0] avs_readdata_o, // read data
  output logic avs_waitrequest_o, // stall
  output logic [1:0] avs_response_o, // 00 okay, 10 slave error
  // flash array side
  input wire logic [127:0] signature_i, // self-test signature
  input wire logic last_load_word_i, // last load-register word written
  output logic [1:0] read_source_o, // read_source_type encoding
  output logic buffer_bypass_o, // reads unbuffered
  output logic async_read_o, // asynchronous read timing
  output logic [7:0] wait_state_count_o, // wait states per beat
  output logic buffer_invalidate_o, // drop both buffer lines
  output logic transfer_reg_set_o, // set whole read transfer register
  output logic latch_preset_o, // preset data latches to ones
  output logic program_request_o, // programming requested
  output logic load_strobe_o, // write loaded data to flash
  output logic erase_strobe_o, // erase request (never protection sector)
  output logic power_down_o, // flash in power down
  output logic chip_select_o, // flash active
  output logic program_erase_allowed_o, // protect and enable both permit
  output logic [15:0] program_time_o, // program timer field
  output logic [11:0] program_clock_divider_o, // program clock divider
  output logic [16:0] selftest_start_o, // self-test start word
  output logic [16:0] selftest_stop_o // self-test stop word
);

  //////////////////////////////////////////////////////////////////////////
  // storage
  logic [15:0] flash_control; // control bits, bit 15 always stored 0
  logic [15:0] program_time; // program timer register
  logic [15:0] bridge_wait_states; // wait states and buffer options
  logic [11:0] program_clock_divider; // divider setting
  logic [16:0] selftest_start_address; // self-test start
  logic [16:0] selftest_stop_address; // self-test stop
  logic [31:0] irq_pending; // sticky interrupt status
  logic [31:0] irq_mask; // interrupt enables
  logic ack; // one-cycle answer phase
  logic [31:0] rdata; // registered read data
  logic [1:0] resp; // registered response
  logic init_pending; // invalidate after reset
  logic load_pipe; // load pulse stage, one cycle behind the request

  //////////////////////////////////////////////////////////////////////////
  // bus decode
  wire req = (avs_read_i | avs_write_i) & ~ack; // new request
  wire wr = avs_write_i & ~ack; // write accepted now
  wire [31:0] bmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
                       {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
  wire [31:0] wdata = avs_writedata_i & bmask; // enabled data only
  wire sel_ctl = avs_address_i == OFF_FLASH_CONTROL;
  wire sel_ptr = avs_address_i == OFF_PROGRAM_TIME;
  wire sel_wst = avs_address_i == OFF_BRIDGE_WAIT_STATES;
  wire sel_div = avs_address_i == OFF_PROGRAM_CLOCK_DIVIDER;
  wire sel_sta = avs_address_i == OFF_SELFTEST_START_ADDRESS;
  wire sel_sto = avs_address_i == OFF_SELFTEST_STOP_ADDRESS;
  wire sel_sw0 = avs_address_i == OFF_SIGNATURE_WORD_0;
  wire sel_sw1 = avs_address_i == OFF_SIGNATURE_WORD_1;
  wire sel_sw2 = avs_address_i == OFF_SIGNATURE_WORD_2;
  wire sel_sw3 = avs_address_i == OFF_SIGNATURE_WORD_3;
  wire sel_iec = avs_address_i == OFF_IRQ_ENABLE_CLEAR;
  wire sel_ies = avs_address_i == OFF_IRQ_ENABLE_SET;
  wire sel_ipd = avs_address_i == OFF_IRQ_PENDING;
  wire sel_imk = avs_address_i == OFF_IRQ_MASK;
  wire sel_ipc = avs_address_i == OFF_IRQ_PENDING_CLEAR;
  wire sel_ips = avs_address_i == OFF_IRQ_PENDING_SET;
  wire sel_cfg = sel_ctl | sel_ptr | sel_wst | sel_div | sel_sta | sel_sto;
  wire sel_rd = sel_cfg | sel_sw0 | sel_sw1 | sel_sw2 | sel_sw3 | sel_ipd
                | sel_imk;
  wire sel_wr = sel_cfg | sel_iec | sel_ies | sel_ipc | sel_ips;
  wire bad = avs_read_i ? ~sel_rd : ~sel_wr; // unmapped or wrong direction
  wire ctl_wr = wr & sel_ctl; // control register write
  // merge of a byte-masked write into the control bits
  wire [15:0] ctl_merge = (flash_control & ~bmask[15:0]) | wdata[15:0];
  // load request bit written as one, in any mode; program mode gates only the strobe
  wire load_bit = ctl_wr & wdata[BIT_LOAD_REQUEST];

  //////////////////////////////////////////////////////////////////////////
  // read multiplexer
  wire [31:0] next_rdata =
      sel_ctl ? {16'h0000, flash_control} :
      sel_ptr ? {16'h0000, program_time} :
      sel_wst ? {16'h0000, bridge_wait_states} :
      sel_div ? {20'h00000, program_clock_divider} :
      sel_sta ? {15'h0000, selftest_start_address} :
      sel_sto ? {15'h0000, selftest_stop_address} :
      sel_sw0 ? signature_i[31:0] :
      sel_sw1 ? signature_i[63:32] :
      sel_sw2 ? signature_i[95:64] :
      sel_sw3 ? signature_i[127:96] :
      sel_ipd ? irq_pending :
      sel_imk ? irq_mask : 32'h00000000;

  //////////////////////////////////////////////////////////////////////////
  // handshake: waitrequest drops in the cycle after the request
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      ack <= 1'b0;
      rdata <= 32'h00000000;
      resp <= 2'h0;
    end
    else
    begin
      ack <= req;
      if (req)
      begin
        rdata <= avs_read_i ? next_rdata : 32'h00000000;
        resp <= bad ? 2'h2 : 2'h0;
      end
    end
  end

  assign avs_waitrequest_o = (avs_read_i | avs_write_i) & ~ack;
  assign avs_readdata_o = rdata;
  assign avs_response_o = resp;

  //////////////////////////////////////////////////////////////////////////
  // control register
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
      flash_control <= RST_FLASH_CONTROL;
    else if (ctl_wr)
      flash_control <= ctl_merge & FLASH_CONTROL_WMASK;
  end

  //////////////////////////////////////////////////////////////////////////
  // configuration registers
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      program_time <= RST_PROGRAM_TIME;
      bridge_wait_states <= RST_BRIDGE_WAIT_STATES;
      program_clock_divider <= RST_PROGRAM_CLOCK_DIVIDER;
      selftest_start_address <= RST_SELFTEST_ADDRESS;
      selftest_stop_address <= RST_SELFTEST_ADDRESS;
    end
    else if (wr)
    begin
      if (sel_ptr)
        program_time <= (program_time & ~bmask[15:0]) | wdata[15:0];
      if (sel_wst)
        bridge_wait_states <= ((bridge_wait_states & ~bmask[15:0])
                               | wdata[15:0]) & WAIT_STATES_WMASK;
      if (sel_div)
        program_clock_divider <= (program_clock_divider & ~bmask[11:0])
                                 | wdata[11:0];
      if (sel_sta)
        selftest_start_address <= (selftest_start_address & ~bmask[16:0])
                                  | wdata[16:0];
      if (sel_sto)
        selftest_stop_address <= (selftest_stop_address & ~bmask[16:0])
                                 | wdata[16:0];
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // interrupt status and enable; set wins over clear
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      irq_pending <= RST_IRQ;
      irq_mask <= RST_IRQ;
    end
    else if (wr)
    begin
      if (sel_ips)
        irq_pending <= irq_pending | wdata;
      else if (sel_ipc)
        irq_pending <= irq_pending & ~wdata;
      if (sel_ies)
        irq_mask <= irq_mask | wdata;
      else if (sel_iec)
        irq_mask <= irq_mask & ~wdata;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // flash strobes
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      init_pending <= 1'b1;
      load_pipe <= 1'b0;
    end
    else
    begin
      init_pending <= 1'b0;
      // load on write or on last word
      load_pipe <= load_bit | last_load_word_i;
    end
  end

  assign program_erase_allowed_o = flash_control[BIT_WRITE_PROTECT]
                                   & ~flash_control[BIT_WRITE_ENABLE_N];
  assign load_strobe_o = load_pipe & program_erase_allowed_o
                         & flash_control[BIT_PROGRAM_NOT_ERASE];
  assign erase_strobe_o = flash_control[BIT_PROGRAM_REQUEST]
                          & ~flash_control[BIT_PROGRAM_NOT_ERASE]
                          & ~flash_control[BIT_PROTECTION_SECTOR_SELECT]
                          & program_erase_allowed_o;
  assign program_request_o = flash_control[BIT_PROGRAM_REQUEST]
                             & flash_control[BIT_PROGRAM_NOT_ERASE]
                             & program_erase_allowed_o;
  assign transfer_reg_set_o = flash_control[BIT_BUFFER_CLEAR];
  assign latch_preset_o = flash_control[BIT_LATCH_PRESET];
  assign power_down_o = flash_control[BIT_POWER_DOWN];
  assign chip_select_o = flash_control[BIT_CHIP_SELECT];
  assign async_read_o = flash_control[BIT_ASYNC_READ_SELECT];

  //////////////////////////////////////////////////////////////////////////
  // read source: protection sector overlaps array addresses
  wire special_read = flash_control[BIT_DATA_LATCH_READ]
                      | flash_control[BIT_PROTECTION_SECTOR_SELECT];
  assign read_source_o =
      flash_control[BIT_PROTECTION_SECTOR_SELECT] ? SRC_PROTECTION_SECTOR :
      flash_control[BIT_DATA_LATCH_READ] ? SRC_DATA_LATCH :
      flash_control[BIT_SECTOR_LATCH_READ] ? SRC_SECTOR_LATCH : SRC_ARRAY;
  assign buffer_bypass_o = flash_control[BIT_BUFFER_BYPASS] | special_read;
  assign wait_state_count_o = bridge_wait_states[7:0];
  assign buffer_invalidate_o = init_pending | (wr & sel_cfg) | special_read;
  assign program_time_o = program_time;
  assign program_clock_divider_o = program_clock_divider;
  assign selftest_start_o = selftest_start_address;
  assign selftest_stop_o = selftest_stop_address;

  //////////////////////////////////////////////////////////////////////////
  // assertions
  // load bit reads back zero
  AST_LOAD_READS_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    flash_control[BIT_LOAD_REQUEST] == 1'b0)
    else $error("load request bit stored as one");
  AST_RESERVED_ZERO: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    ack && $past(avs_read_i && sel_ctl) |-> rdata[31:16] == 16'h0000
    && rdata[8] == 1'b0 && rdata[3] == 1'b0)
    else $error("reserved control bits read nonzero");
  AST_NO_ERASE_SPECIAL: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    flash_control[BIT_PROTECTION_SECTOR_SELECT] |-> !erase_strobe_o)
    else $error("erase while protection sector selected");
  AST_SPECIAL_BYPASS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    special_read |-> buffer_bypass_o && buffer_invalidate_o)
    else $error("special read left buffering on");
  AST_LOAD_GATED: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    load_strobe_o |-> flash_control[BIT_WRITE_PROTECT]
    && !flash_control[BIT_WRITE_ENABLE_N])
    else $error("load while program and erase forbidden");
  // write of bit 15 loads next cycle
  AST_LOAD_FOLLOWS: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    load_bit ##1 (program_erase_allowed_o
    && flash_control[BIT_PROGRAM_NOT_ERASE]) |-> load_strobe_o)
    else $error("load request did not strobe");
  AST_SOURCE_SPECIAL: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    ctl_wr && wdata[BIT_PROTECTION_SECTOR_SELECT]
    && avs_byteenable_i[0] |=> read_source_o == SRC_PROTECTION_SECTOR)
    else $error("protection sector not selected");
  AST_PENDING_SET: assert property (@(posedge mclk_i) disable iff (!rst_b_i)
    wr && sel_ips |=> (irq_pending & $past(wdata)) == $past(wdata))
    else $error("pending set lost");
  AST_CFG_INVALIDATE: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    wr && sel_cfg |-> buffer_invalidate_o)
    else $error("config access kept buffers");
  AST_SIGNATURE_READ: assert property (@(posedge mclk_i)
    disable iff (!rst_b_i)
    req && avs_read_i && sel_sw0 |=> ack && rdata == $past(signature_i[31:0]))
    else $error("signature word 0 misread");
  COV_LOAD: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    load_strobe_o);
  COV_ERASE: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    erase_strobe_o);
  COV_LATCH_READ: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    read_source_o == SRC_DATA_LATCH);
  COV_BAD: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    ack && resp == 2'h2);

endmodule : flash_control_regs
`default_nettype wire

//--- flash_array_model.sv
// behavioural flash array side: signature source, last-word pulses
`timescale 1ns/1ps
`default_nettype none
module flash_array_model
(
  input wire logic mclk_i, // system clock
  input wire logic rst_b_i, // sync reset, active low
  input wire logic [127:0] sig_data_i, // next signature result
  input wire logic last_word_req_i, // bench asks for a last-word pulse
  input wire logic load_strobe_i, // load strobe from controller
  output logic [127:0] signature_o, // signature towards controller
  output logic last_load_word_o, // last load word written
  output logic [7:0] load_count_o // loads seen so far
);
  ////////////////////////////////////////////////////////////////////////
  // bench code runs outside array
  always_ff @(posedge mclk_i)
  begin
    if (!rst_b_i)
    begin
      last_load_word_o <= 1'b0;
      load_count_o <= 8'h00;
      signature_o <= 128'h0;
    end
    else
    begin
      last_load_word_o <= last_word_req_i;
      signature_o <= sig_data_i;
      load_count_o <= load_count_o + {7'h00, load_strobe_i};
    end
  end
endmodule : flash_array_model
`default_nettype wire

//--- flash_control_regs_tb_top.sv
// self-checking bench for the flash controller register block
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin fail_count++; \
  $display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module flash_control_regs_tb_top;
  import flash_control_pkg::*;
  logic mclk, rst_b, rd, wr, wait_r, lw, lwreq, bypass, async, inval;
  logic xset, preset, preq, lstb, erase, pdn, cs, allowed;
  logic [11:0] addr; // bus address
  logic [31:0] wdata, rdata, v, r; // bus data, scratch
  logic [1:0] resp, src, es; // response, read source
  logic [7:0] wsc, lc; // wait states, load count
  logic [127:0] sig_d, sig; // signature path
  logic [15:0] ptm; // program timer output
  logic [11:0] pdiv; // clock divider output
  logic [16:0] sst, ssp; // self-test address outputs
  logic [33:0] exp_q[$]; // expected read notes
  logic [33:0] note; // oldest note
  int fail_count, compares, i;
  ////////////////////////////////////////////////////////////////////////
  flash_control_regs flash_control_regs_i (.mclk_i(mclk), .rst_b_i(rst_b),
    .avs_address_i(addr), .avs_read_i(rd), .avs_write_i(wr),
    .avs_writedata_i(wdata), .avs_byteenable_i(4'hf),
    .avs_readdata_o(rdata), .avs_waitrequest_o(wait_r),
    .avs_response_o(resp), .signature_i(sig), .last_load_word_i(lw),
    .read_source_o(src), .buffer_bypass_o(bypass), .async_read_o(async),
    .wait_state_count_o(wsc), .buffer_invalidate_o(inval),
    .transfer_reg_set_o(xset), .latch_preset_o(preset),
    .program_request_o(preq), .load_strobe_o(lstb), .erase_strobe_o(erase),
    .power_down_o(pdn), .chip_select_o(cs),
    .program_erase_allowed_o(allowed), .program_time_o(ptm),
    .program_clock_divider_o(pdiv), .selftest_start_o(sst),
    .selftest_stop_o(ssp));
  flash_array_model flash_array_model_i (.mclk_i(mclk), .rst_b_i(rst_b),
    .sig_data_i(sig_d), .last_word_req_i(lwreq), .load_strobe_i(lstb),
    .signature_o(sig), .last_load_word_o(lw), .load_count_o(lc));
  ////////////////////////////////////////////////////////////////////////
  // clock, 40 ns period
  initial
  begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  // monitor: compare each read answer with the oldest note
  always @(posedge mclk)
  begin
    if (rd === 1'b1 && wait_r === 1'b0)
    begin
      note = (exp_q.size() > 0) ? exp_q.pop_front() : 34'h0;
      `CHK({resp, rdata}, note)
    end
  end
  // verdict and end of run
  task automatic wrap_up;
    $display("counts: compares=%0d mismatches=%0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : wrap_up
  // one bus cycle, held until waitrequest is seen low
  task automatic acc(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    do
    begin
      @(posedge mclk);
      n++;
    end
    while (wait_r !== 1'b0 && n < 20);
    if (wait_r !== 1'b0)
    begin
      fail_count++;
      wrap_up();
    end
    wr <= 1'b0;
    rd <= 1'b0;
  endtask : acc
  // read with an expected word and response
  task automatic rdx(input logic [11:0] a, input logic [31:0] e,
                     input logic [1:0] p);
    exp_q.push_back({p, e});
    acc(1'b0, a, 32'h0);
  endtask : rdx
  // write control, read it back, check the flash-side outputs
  task automatic ctl(input logic [31:0] c);
    acc(1'b1, OFF_FLASH_CONTROL, c);
    rdx(OFF_FLASH_CONTROL, c & {16'h0, FLASH_CONTROL_WMASK}, 2'b00);
    es = c[6] ? 2'd3 : (c[5] ? 2'd1 : (c[11] ? 2'd2 : 2'd0));
    `CHK(src, es)
    `CHK(bypass, c[13] | c[5] | c[6])
    `CHK(inval, c[5] | c[6])
    `CHK(async, c[4])
    `CHK(xset, c[14])
    `CHK(preset, c[10])
    `CHK(pdn, c[9])
    `CHK(cs, c[0])
    `CHK(allowed, c[7] & ~c[2])
    `CHK(preq, c[12] & c[1] & c[7] & ~c[2])
    `CHK(erase, c[12] & ~c[1] & ~c[6] & c[7] & ~c[2])
  endtask : ctl
  ////////////////////////////////////////////////////////////////////////
  initial
  begin
    {rst_b, rd, wr, lwreq, fail_count, compares} = '0;
    addr = 12'h000;
    wdata = 32'h0;
    sig_d = 128'h0;
    void'($urandom(74282));
    repeat (10) @(posedge mclk);
    rst_b <= 1'b1;
    // reset values
    rdx(OFF_FLASH_CONTROL, 32'h00000005, 2'b00);
    rdx(OFF_BRIDGE_WAIT_STATES, 32'h0000c004, 2'b00);
    rdx(OFF_PROGRAM_TIME, 32'h0, 2'b00);
    rdx(OFF_PROGRAM_CLOCK_DIVIDER, 32'h0, 2'b00);
    rdx(OFF_SELFTEST_STOP_ADDRESS, 32'h0, 2'b00);
    rdx(OFF_IRQ_PENDING, 32'h0, 2'b00);
    `CHK(wsc, 8'h04)
    $display("test reset done");
    // random control values, one read source at a time
    for (i = 0; i < 16; i++)
    begin
      v = $urandom & 32'h00007697;
      v = v | (32'h1 << (i % 4 == 1 ? 5 : i % 4 == 2 ? 6 : 11));
      ctl((i % 4 == 0) ? (v & 32'hfffff7ff) : v);
      r = $urandom & {16'h0, WAIT_STATES_WMASK};
      acc(1'b1, OFF_BRIDGE_WAIT_STATES, r);
      rdx(OFF_BRIDGE_WAIT_STATES, r, 2'b00);
      `CHK(wsc, r[7:0])
    end
    ctl(32'h000010c1);
    ctl(32'h00001081);
    ctl(32'h00001083);
    $display("test control done");
    // load by bit 15 and by last word, then with protection on
    ctl(32'h00000083);
    v = {24'h0, lc};
    acc(1'b1, OFF_FLASH_CONTROL, 32'h00008083);
    repeat (3) @(posedge mclk);
    `CHK(lc, v[7:0] + 8'h01)
    rdx(OFF_FLASH_CONTROL, 32'h00000083, 2'b00);
    lwreq <= 1'b1;
    @(posedge mclk);
    lwreq <= 1'b0;
    repeat (3) @(posedge mclk);
    `CHK(lc, v[7:0] + 8'h02)
    ctl(32'h00000003);
    acc(1'b1, OFF_FLASH_CONTROL, 32'h00008003);
    repeat (3) @(posedge mclk);
    `CHK(lc, v[7:0] + 8'h02)
    $display("test load done");
    // signature words
    sig_d <= {$urandom, $urandom, $urandom, $urandom};
    repeat (3) @(posedge mclk);
    for (i = 0; i < 4; i++)
      rdx(OFF_SIGNATURE_WORD_0 + 12'(4*i), sig_d[32*i +: 32], 2'b00);
    $display("test signature done");
    // configuration registers: read back and flash-side outputs
    r = $urandom;
    acc(1'b1, OFF_PROGRAM_TIME, r);
    rdx(OFF_PROGRAM_TIME, {16'h0, r[15:0]}, 2'b00);
    `CHK(ptm, r[15:0])
    acc(1'b1, OFF_PROGRAM_CLOCK_DIVIDER, r);
    rdx(OFF_PROGRAM_CLOCK_DIVIDER, {20'h0, r[11:0]}, 2'b00);
    `CHK(pdiv, r[11:0])
    acc(1'b1, OFF_SELFTEST_START_ADDRESS, r);
    rdx(OFF_SELFTEST_START_ADDRESS, {15'h0, r[16:0]}, 2'b00);
    `CHK(sst, r[16:0])
    acc(1'b1, OFF_SELFTEST_STOP_ADDRESS, ~r);
    rdx(OFF_SELFTEST_STOP_ADDRESS, {15'h0, ~r[16:0]}, 2'b00);
    `CHK(ssp, ~r[16:0])
    $display("test config done");
    // refused accesses and interrupt status set and clear
    rdx(12'h004, 32'h0, 2'b10);
    rdx(OFF_IRQ_PENDING_SET, 32'h0, 2'b10);
    r = $urandom;
    acc(1'b1, OFF_IRQ_PENDING_SET, r);
    rdx(OFF_IRQ_PENDING, r, 2'b00);
    acc(1'b1, OFF_IRQ_PENDING_CLEAR, r);
    rdx(OFF_IRQ_PENDING, 32'h0, 2'b00);
    $display("test refusal done");
    repeat (3) @(posedge mclk);
    wrap_up();
  end
endmodule : flash_control_regs_tb_top
`default_nettype wire
